// ---- hdl/clfa_top.sv ----
// Communication-loss supervision and I/O selection between master and drive.
// Assumes a same-clock parameter port and message-valid pulse; the 16-bit
// drive-word strap arrives asynchronously from the drive side.
`timescale 1ns/1ps
`default_nettype none
`include "clfa_defs.svh"
module clfa_top #(
  parameter int unsigned SEC_CYCLES = `CLFA_SEC_CYCLES
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic PAR_WR,
  input wire logic PAR_RD,
  input wire logic [5:0] PAR_ADDR,
  input wire logic [31:0] PAR_WDATA,
  output logic [31:0] PAR_RDATA,
  input wire logic MSG_VALID,
  input wire logic [15:0] NET_CMD,
  input wire logic [31:0] NET_REF,
  input wire logic [31:0] NET_AUX_A,
  input wire logic [31:0] NET_AUX_B,
  input wire logic [31:0] NET_AUX_C,
  input wire logic [31:0] NET_AUX_D,
  input wire logic DRV_REF16_PIN,
  output logic [15:0] DRV_CMD,
  output logic [31:0] DRV_REF,
  output logic [31:0] DRV_AUX_A,
  output logic [31:0] DRV_AUX_B,
  output logic [31:0] DRV_AUX_C,
  output logic [31:0] DRV_AUX_D,
  output logic DRV_CMD_EN,
  output logic [3:0] DRV_AUX_EN,
  output logic DRV_FAULT,
  output logic DRV_STOP,
  output logic COMM_LOSS,
  output logic FLT_CFG_ERR
);
  localparam int AN = `CLFA_AUX_N;

  // Write strobe for one register index
  function automatic logic wr_hit(input logic wr, input logic [5:0] a,
                                  input logic [5:0] ofs);
    wr_hit = wr && (a == ofs);
  endfunction

  logic [15:0] timeout_r;
  logic [15:0] timeout_nxt;
  clfa_pkg::clfa_action_e action_r;
  clfa_pkg::clfa_action_e action_nxt;
  clfa_pkg::clfa_restart_e rs_code_r;
  clfa_pkg::clfa_restart_e rs_code_nxt;
  logic restart_r;
  logic [`CLFA_IOEN_W-1:0] io_en_r;
  logic [`CLFA_IOEN_W-1:0] io_en_nxt;
  logic [`CLFA_IOEN_W-1:0] io_act_r;
  logic [15:0] fb_cmd_r;
  logic [15:0] fb_cmd_nxt;
  logic [31:0] fb_ref_r;
  logic [31:0] fb_ref_nxt;
  logic [AN-1:0][31:0] fb_aux_r;
  logic [AN-1:0][31:0] fb_aux_nxt;
  logic ref16_s1_r;
  logic ref16_s2_r;
  logic [31:0] rdata_r;
  logic [15:0] cmd_r;
  logic [31:0] ref_r;
  logic [AN-1:0][31:0] aux_r;
  logic fault_r;
  logic stop_r;
  logic [15:0] cmd_nxt;
  logic [31:0] ref_nxt;
  logic [AN-1:0][31:0] aux_nxt;
  logic fault_nxt;
  logic stop_nxt;
  logic loss;
  logic fb_err;
  logic [31:0] rd_mux;

  wire wr_timeout = wr_hit(PAR_WR, PAR_ADDR, `CLFA_OFS_TIMEOUT);
  wire wr_restart = wr_hit(PAR_WR, PAR_ADDR, `CLFA_OFS_RESTART);
  wire wr_action = wr_hit(PAR_WR, PAR_ADDR, `CLFA_OFS_ACTION);
  wire wr_ioen = wr_hit(PAR_WR, PAR_ADDR, `CLFA_OFS_IOEN);
  wire wr_fbcmd = wr_hit(PAR_WR, PAR_ADDR, `CLFA_OFS_FB_CMD);
  wire wr_fbref = wr_hit(PAR_WR, PAR_ADDR, `CLFA_OFS_FB_REF);
  wire [15:0] wd16 = PAR_WDATA[15:0];
  wire timeout_ok = (wd16 <= `CLFA_TIMEOUT_MAX);
  wire action_ok = (wd16 <= {13'h0000, `CLFA_ACTION_MAX});
  wire go_restart = wr_restart && (wd16 == 16'h0001);
  wire go_defaults = wr_restart && (wd16 == 16'h0002);
  wire msg_or_restart = MSG_VALID | restart_r;

  // Restoring defaults rewrites the stored values only; the streams in
  // use change at the restart that must follow
  assign timeout_nxt = go_defaults ? `CLFA_RST_TIMEOUT :
                       (wr_timeout && timeout_ok) ? wd16 :
                       timeout_r;
  assign action_nxt = go_defaults ? clfa_pkg::CLFA_ACT_FAULT :
                      (wr_action && action_ok) ?
                      clfa_pkg::clfa_action_e'(PAR_WDATA[2:0]) :
                      action_r;
  assign io_en_nxt = go_defaults ? `CLFA_RST_IOEN :
                     wr_ioen ? PAR_WDATA[`CLFA_IOEN_W-1:0] : io_en_r;
  assign fb_cmd_nxt = go_defaults ? `CLFA_RST_FB16 :
                      wr_fbcmd ? wd16 : fb_cmd_r;
  assign fb_ref_nxt = go_defaults ? `CLFA_RST_FB32 :
                      wr_fbref ? PAR_WDATA : fb_ref_r;
  assign rs_code_nxt = restart_r ? clfa_pkg::CLFA_RS_READY :
                       go_restart ? clfa_pkg::CLFA_RS_RESTART :
                       go_defaults ? clfa_pkg::CLFA_RS_DEFAULTS :
                       rs_code_r;

  genvar i;
  generate
    for (i = 0; i < AN; i++) begin : g_fb
      wire wr_aux = wr_hit(PAR_WR, PAR_ADDR,
                           `CLFA_OFS_FB_AUX + 6'(i));
      assign fb_aux_nxt[i] = go_defaults ? `CLFA_RST_FB32 :
                             wr_aux ? PAR_WDATA : fb_aux_r[i];
    end
  endgenerate

  // Upper words must be zero for every enabled stream of a 16-bit drive
  logic [AN:0] upper_bad;
  assign upper_bad[0] = io_act_r[`CLFA_IOEN_CMD] &&
                        (fb_ref_r[31:16] != 16'h0000);
  generate
    for (i = 0; i < AN; i++) begin : g_upper
      assign upper_bad[i+1] = io_act_r[i+1] &&
                              (fb_aux_r[i][31:16] != 16'h0000);
    end
  endgenerate
  assign fb_err = ref16_s2_r & (|upper_bad);

  assign rd_mux =
    (PAR_ADDR == `CLFA_OFS_TIMEOUT) ? {16'h0000, timeout_r} :
    (PAR_ADDR == `CLFA_OFS_RESTART) ? {30'h00000000, rs_code_r} :
    (PAR_ADDR == `CLFA_OFS_ACTION) ? {29'h00000000, action_r} :
    (PAR_ADDR == `CLFA_OFS_IOEN) ? {27'h0000000, io_en_r} :
    (PAR_ADDR == `CLFA_OFS_IOACT) ? {27'h0000000, io_act_r} :
    (PAR_ADDR == `CLFA_OFS_FB_CMD) ? {16'h0000, fb_cmd_r} :
    (PAR_ADDR == `CLFA_OFS_FB_REF) ? fb_ref_r :
    (PAR_ADDR == `CLFA_OFS_FB_AUX) ? fb_aux_r[0] :
    (PAR_ADDR == `CLFA_OFS_FB_AUX + 6'h01) ? fb_aux_r[1] :
    (PAR_ADDR == `CLFA_OFS_FB_AUX + 6'h02) ? fb_aux_r[2] :
    (PAR_ADDR == `CLFA_OFS_FB_AUX + 6'h03) ? fb_aux_r[3] :
    32'h00000000;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      timeout_r <= `CLFA_RST_TIMEOUT;
      action_r <= clfa_pkg::CLFA_ACT_FAULT;
      rs_code_r <= clfa_pkg::CLFA_RS_READY;
      io_en_r <= `CLFA_RST_IOEN;
      fb_cmd_r <= `CLFA_RST_FB16;
      fb_ref_r <= `CLFA_RST_FB32;
      fb_aux_r <= '0;
      restart_r <= 1'b0;
      ref16_s1_r <= 1'b0;
      ref16_s2_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      timeout_r <= timeout_nxt;
      action_r <= action_nxt;
      rs_code_r <= rs_code_nxt;
      io_en_r <= io_en_nxt;
      fb_cmd_r <= fb_cmd_nxt;
      fb_ref_r <= fb_ref_nxt;
      fb_aux_r <= fb_aux_nxt;
      restart_r <= go_restart;
      ref16_s1_r <= DRV_REF16_PIN;
      ref16_s2_r <= ref16_s1_r;
      if (PAR_RD) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // Power-up counts as a restart: the active set starts from the default
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      io_act_r <= `CLFA_RST_IOEN;
    end else if (restart_r) begin
      io_act_r <= io_en_r;
    end
  end

  clfa_sec_timer #(
    .TICKS(SEC_CYCLES)
  ) u_timer (
    .clk(CLK),
    .nrst(NRST),
    .clr(msg_or_restart),
    .timeout(timeout_r[7:0]),
    .loss(loss)
  );

  clfa_out_sel u_sel (
    .action(action_r),
    .loss(loss),
    .fb_err(fb_err),
    .io_act(io_act_r),
    .net_cmd(NET_CMD),
    .net_ref(NET_REF),
    .net_aux({NET_AUX_D, NET_AUX_C, NET_AUX_B, NET_AUX_A}),
    .fb_cmd(fb_cmd_r),
    .fb_ref(fb_ref_r),
    .fb_aux(fb_aux_r),
    .hold_cmd(cmd_r),
    .hold_ref(ref_r),
    .hold_aux(aux_r),
    .cmd(cmd_nxt),
    .ref_w(ref_nxt),
    .aux(aux_nxt),
    .fault(fault_nxt),
    .stop(stop_nxt)
  );

  // A restart drops the drive words to zero for one cycle
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cmd_r <= 16'h0000;
      ref_r <= 32'h00000000;
      aux_r <= '0;
      fault_r <= 1'b0;
      stop_r <= 1'b0;
    end else if (restart_r) begin
      cmd_r <= 16'h0000;
      ref_r <= 32'h00000000;
      aux_r <= '0;
      fault_r <= 1'b0;
      stop_r <= 1'b0;
    end else begin
      cmd_r <= cmd_nxt;
      ref_r <= ref_nxt;
      aux_r <= aux_nxt;
      fault_r <= fault_nxt;
      stop_r <= stop_nxt;
    end
  end

  assign PAR_RDATA = rdata_r;
  assign DRV_CMD = cmd_r;
  assign DRV_REF = ref_r;
  assign DRV_AUX_A = aux_r[0];
  assign DRV_AUX_B = aux_r[1];
  assign DRV_AUX_C = aux_r[2];
  assign DRV_AUX_D = aux_r[3];
  assign DRV_CMD_EN = io_act_r[`CLFA_IOEN_CMD];
  assign DRV_AUX_EN = io_act_r[`CLFA_IOEN_W-1:1];
  assign DRV_FAULT = fault_r;
  assign DRV_STOP = stop_r;
  assign COMM_LOSS = loss;
  assign FLT_CFG_ERR = fb_err;

  restart_ready_a: assert property (@(posedge CLK)
    disable iff (!NRST) restart_r |=> rs_code_r == clfa_pkg::CLFA_RS_READY)
    else $error("restart control not ready after restart");
  io_apply_a: assert property (@(posedge CLK) disable iff (!NRST)
    go_restart |=> ##1 io_act_r == $past(io_en_r))
    else $error("enables not applied at restart");
  io_frozen_a: assert property (@(posedge CLK) disable iff (!NRST)
    !restart_r |=> $stable(io_act_r))
    else $error("active enables changed without restart");
  defaults_set_a: assert property (@(posedge CLK) disable iff (!NRST)
    go_defaults |=> timeout_r == `CLFA_RST_TIMEOUT &&
    action_r == clfa_pkg::CLFA_ACT_FAULT && $stable(io_act_r))
    else $error("defaults not restored");
  fallback_out_a: assert property (@(posedge CLK) disable iff (!NRST)
    (loss && !restart_r && action_r == clfa_pkg::CLFA_ACT_SEND &&
     io_act_r[`CLFA_IOEN_CMD]) |=> DRV_CMD == $past(fb_cmd_r) &&
    DRV_REF == $past(fb_ref_r))
    else $error("fallback words not delivered");
  fault_stop_a: assert property (@(posedge CLK) disable iff (!NRST)
    (loss && !restart_r && action_r == clfa_pkg::CLFA_ACT_FAULT) |=>
    DRV_FAULT && DRV_STOP && DRV_CMD == 16'h0000)
    else $error("fault response missing");
  stream_off_a: assert property (@(posedge CLK) disable iff (!NRST)
    !io_act_r[`CLFA_IOEN_CMD] |=> DRV_CMD == 16'h0000 &&
    DRV_REF == 32'h00000000)
    else $error("disabled stream carries data");
  upper_fault_a: assert property (@(posedge CLK) disable iff (!NRST)
    (loss && !restart_r && fb_err &&
     action_r == clfa_pkg::CLFA_ACT_SEND) |=> DRV_FAULT)
    else $error("nonzero upper word did not fault");
  timeout_range_a: assert property (@(posedge CLK) disable iff (!NRST)
    (wr_timeout && !timeout_ok) |=> $stable(timeout_r))
    else $error("out-of-range timeout accepted");
  action_range_a: assert property (@(posedge CLK) disable iff (!NRST)
    (wr_action && !action_ok) |=> $stable(action_r))
    else $error("out-of-range loss response accepted");
  stop_only_a: assert property (@(posedge CLK) disable iff (!NRST)
    (loss && !restart_r && action_r == clfa_pkg::CLFA_ACT_STOP) |=>
    DRV_STOP && !DRV_FAULT && DRV_CMD == 16'h0000)
    else $error("stop response wrong");
  zero_data_a: assert property (@(posedge CLK) disable iff (!NRST)
    (loss && !restart_r && action_r == clfa_pkg::CLFA_ACT_ZERO) |=>
    !DRV_STOP && !DRV_FAULT && DRV_CMD == 16'h0000 &&
    DRV_REF == 32'h00000000)
    else $error("zero data response wrong");
  hold_last_a: assert property (@(posedge CLK) disable iff (!NRST)
    (loss && !restart_r && action_r == clfa_pkg::CLFA_ACT_HOLD) |=>
    $stable(DRV_CMD) && $stable(DRV_REF) && !DRV_STOP)
    else $error("hold response changed the drive words");
  restart_wipe_a: assert property (@(posedge CLK) disable iff (!NRST)
    restart_r |=> DRV_CMD == 16'h0000 && DRV_REF == 32'h00000000 &&
    !DRV_FAULT)
    else $error("restart left drive words set");
  net_pass_a: assert property (@(posedge CLK) disable iff (!NRST)
    (!loss && !restart_r && io_act_r[`CLFA_IOEN_CMD]) |=>
    DRV_CMD == $past(NET_CMD) && DRV_REF == $past(NET_REF))
    else $error("enabled stream not passed through");
endmodule
`default_nettype wire

// ---- hdl/clfa_defs.svh ----
// Constants of the communication-loss supervision block.
// Assumes CLK runs at 50 MHz and registers sit on a 6-bit parameter index.
// Behaviour
// - One enable bit per I/O stream
// - Enable changes apply only after restart
// - Declare loss when master silent past timeout
// - Timeout seconds, 0 to 180, default 10
// - Zero timeout disables loss detection
// - New timeout acts immediately
// - Loss responses: fault, stop, zero, hold, fallback
// - New loss response acts immediately
// - Fallback response delivers stored fallback words
// - Fallback command 16 bits, others 32 bits
// - Nonzero upper fallback word faults 16-bit drive
// - New fallback words act immediately
// - Restart by power cycle or restart control
// - Restart codes: ready, restart, restore defaults
// - Restart control reads ready after restart
`ifndef CLFA_DEFS_SVH
`define CLFA_DEFS_SVH

`define CLFA_OFS_TIMEOUT 6'h0B
`define CLFA_OFS_RESTART 6'h0E
`define CLFA_OFS_ACTION 6'h0F
`define CLFA_OFS_IOEN 6'h10
`define CLFA_OFS_IOACT 6'h11
`define CLFA_OFS_FB_CMD 6'h19
`define CLFA_OFS_FB_REF 6'h1A
`define CLFA_OFS_FB_AUX 6'h1B

`define CLFA_RST_TIMEOUT 16'h000A
`define CLFA_TIMEOUT_MAX 16'h00B4
`define CLFA_RST_IOEN 5'h01
`define CLFA_RST_FB32 32'h00000000
`define CLFA_RST_FB16 16'h0000
`define CLFA_ACTION_MAX 3'h4
`define CLFA_IOEN_W 5
`define CLFA_IOEN_CMD 0
`define CLFA_AUX_N 4

`define CLFA_CLK_PERIOD_NS 20
`define CLFA_SECOND_NS 1000000000
`define CLFA_SEC_CYCLES (`CLFA_SECOND_NS / `CLFA_CLK_PERIOD_NS)

`endif

// ---- hdl/clfa_pkg.sv ----
// Types shared by the communication-loss supervision block.
// Assumes nothing beyond a SystemVerilog compiler.
package clfa_pkg;

  typedef enum logic [2:0] {
    CLFA_ACT_FAULT = 3'h0,
    CLFA_ACT_STOP = 3'h1,
    CLFA_ACT_ZERO = 3'h2,
    CLFA_ACT_HOLD = 3'h3,
    CLFA_ACT_SEND = 3'h4
  } clfa_action_e;

  typedef enum logic [1:0] {
    CLFA_RS_READY = 2'h0,
    CLFA_RS_RESTART = 2'h1,
    CLFA_RS_DEFAULTS = 2'h2
  } clfa_restart_e;

endpackage

// ---- hdl/clfa_sec_timer.sv ----
// Seconds timer that declares loss of master communication.
// Assumes clr is a same-clock pulse for each valid message or restart.
`timescale 1ns/1ps
`default_nettype none
`include "clfa_defs.svh"
module clfa_sec_timer #(
  parameter int unsigned TICKS = `CLFA_SEC_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clr,
  input wire logic [7:0] timeout,
  output logic loss
);
  localparam int unsigned DW = $clog2(TICKS);
  localparam logic [DW-1:0] LAST = DW'(TICKS - 1);

  logic [DW-1:0] div_r;
  logic [DW-1:0] div_nxt;
  logic [7:0] secs_r;
  logic [7:0] secs_nxt;
  logic loss_r;
  logic loss_nxt;
  wire last = (div_r == LAST);
  wire sec_tick = last & ~clr;
  wire expired = (timeout != 8'h00) && (secs_r >= timeout);

  // Divider and seconds count both restart on every message
  assign div_nxt = (clr | last) ? '0 : div_r + 1'b1;
  assign secs_nxt = clr ? 8'h00 :
                    (sec_tick && secs_r != 8'hFF) ? secs_r + 8'h01 :
                    secs_r;
  assign loss_nxt = (clr || timeout == 8'h00) ? 1'b0 :
                    (expired | loss_r);
  assign loss = loss_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_r <= '0;
      secs_r <= 8'h00;
      loss_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      secs_r <= secs_nxt;
      loss_r <= loss_nxt;
    end
  end

  loss_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    clr |=> !loss) else $error("loss not cleared by message");
  zero_off_a: assert property (@(posedge clk) disable iff (!nrst)
    (timeout == 8'h00) |=> !loss) else $error("loss with zero timeout");
  loss_cause_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(loss) |-> $past(expired) && !$past(clr))
    else $error("loss rose without expiry");
  sticky_loss_a: assert property (@(posedge clk) disable iff (!nrst)
    (loss && !clr && timeout != 8'h00) |=> loss)
    else $error("loss dropped without message");
endmodule
`default_nettype wire

// ---- hdl/clfa_out_sel.sv ----
// Selects the words sent to the drive in normal and loss operation.
// Assumes hold_* are the words presently driven out.
`timescale 1ns/1ps
`default_nettype none
`include "clfa_defs.svh"
module clfa_out_sel (
  input wire clfa_pkg::clfa_action_e action,
  input wire logic loss,
  input wire logic fb_err,
  input wire logic [`CLFA_IOEN_W-1:0] io_act,
  input wire logic [15:0] net_cmd,
  input wire logic [31:0] net_ref,
  input wire logic [`CLFA_AUX_N-1:0][31:0] net_aux,
  input wire logic [15:0] fb_cmd,
  input wire logic [31:0] fb_ref,
  input wire logic [`CLFA_AUX_N-1:0][31:0] fb_aux,
  input wire logic [15:0] hold_cmd,
  input wire logic [31:0] hold_ref,
  input wire logic [`CLFA_AUX_N-1:0][31:0] hold_aux,
  output logic [15:0] cmd,
  output logic [31:0] ref_w,
  output logic [`CLFA_AUX_N-1:0][31:0] aux,
  output logic fault,
  output logic stop
);
  wire cmd_en = io_act[`CLFA_IOEN_CMD];
  wire is_send = (action == clfa_pkg::CLFA_ACT_SEND);
  wire is_hold = (action == clfa_pkg::CLFA_ACT_HOLD);
  wire use_net = ~loss;
  wire use_fb = loss & is_send;
  wire use_hold = loss & is_hold;

  // Disabled streams always carry zero
  assign cmd = !cmd_en ? 16'h0000 : use_net ? net_cmd :
               use_fb ? fb_cmd : use_hold ? hold_cmd : 16'h0000;
  assign ref_w = !cmd_en ? 32'h00000000 : use_net ? net_ref :
                 use_fb ? fb_ref : use_hold ? hold_ref : 32'h00000000;

  genvar i;
  generate
    for (i = 0; i < `CLFA_AUX_N; i++) begin : g_aux
      assign aux[i] = !io_act[i+1] ? 32'h00000000 : use_net ? net_aux[i] :
                      use_fb ? fb_aux[i] : use_hold ? hold_aux[i] :
                      32'h00000000;
    end
  endgenerate

  // Unknown codes cannot be stored; an unlisted code would raise neither fault nor stop
  assign fault = loss & ((action == clfa_pkg::CLFA_ACT_FAULT) |
                         (is_send & fb_err));
  assign stop = loss & ((action == clfa_pkg::CLFA_ACT_FAULT) |
                        (action == clfa_pkg::CLFA_ACT_STOP));
endmodule
`default_nettype wire

// ---- bench/clfa_net_master.sv ----
// Behavioural network master: one message per request from the bench.
// Assumes send is a one-cycle request raised just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module clfa_net_master (
  input wire logic clk,
  input wire logic nrst,
  input wire logic send,
  output logic msg_valid,
  output logic [15:0] net_cmd,
  output logic [31:0] net_ref,
  output logic [31:0] net_aux_a,
  output logic [31:0] net_aux_b,
  output logic [31:0] net_aux_c,
  output logic [31:0] net_aux_d
);
  logic [7:0] frame_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      msg_valid <= 1'b0;
      frame_r <= 8'h00;
    end else begin
      msg_valid <= send;
      if (send) begin
        frame_r <= frame_r + 8'h01;
      end
    end
  end

  // Words change with each message; every channel has its own pattern
  assign net_cmd = {8'hC3, frame_r};
  assign net_ref = {24'h00A100, frame_r};
  assign net_aux_a = {24'h00B100, frame_r};
  assign net_aux_b = {24'h00B200, frame_r};
  assign net_aux_c = {24'h00B300, frame_r};
  assign net_aux_d = {24'h00B400, frame_r};
endmodule
`default_nettype wire

// ---- bench/clfa_top_tb_top.sv ----
// Self-checking bench for the communication-loss supervision block.
// Assumes a short seconds divider so that timeouts finish in a few cycles.
`timescale 1ns/1ps
`default_nettype none
`include "clfa_defs.svh"
module clfa_top_tb_top;
  localparam int SEC = 4;
  logic clk, nrst, par_wr, par_rd, send, ref16;
  logic [5:0] par_addr;
  logic [31:0] par_wdata, par_rdata;
  logic msg_valid, drv_cmd_en, drv_fault, drv_stop, comm_loss, flt_cfg_err;
  logic [15:0] net_cmd, drv_cmd;
  logic [31:0] net_ref, na, nb, nc, nd, drv_ref, da, db, dc, dd;
  logic [3:0] drv_aux_en;
  int errors, comparisons, cyc, n;
  logic [5:0] ra [9] = '{6'h0B, 6'h0E, 6'h0F, 6'h10, 6'h11, 6'h19, 6'h1A,
                         6'h1B, 6'h3F};
  logic [31:0] rv [9] = '{32'hA, 32'h0, 32'h0, 32'h1, 32'h1, 32'h0, 32'h0,
                          32'h0, 32'h0};

  clfa_top #(.SEC_CYCLES(SEC)) dut_u (
    .CLK(clk), .NRST(nrst), .PAR_WR(par_wr), .PAR_RD(par_rd),
    .PAR_ADDR(par_addr), .PAR_WDATA(par_wdata), .PAR_RDATA(par_rdata),
    .MSG_VALID(msg_valid), .NET_CMD(net_cmd), .NET_REF(net_ref),
    .NET_AUX_A(na), .NET_AUX_B(nb), .NET_AUX_C(nc), .NET_AUX_D(nd),
    .DRV_REF16_PIN(ref16), .DRV_CMD(drv_cmd), .DRV_REF(drv_ref),
    .DRV_AUX_A(da), .DRV_AUX_B(db), .DRV_AUX_C(dc), .DRV_AUX_D(dd),
    .DRV_CMD_EN(drv_cmd_en), .DRV_AUX_EN(drv_aux_en), .DRV_FAULT(drv_fault),
    .DRV_STOP(drv_stop), .COMM_LOSS(comm_loss), .FLT_CFG_ERR(flt_cfg_err)
  );

  clfa_net_master master_u (
    .clk(clk), .nrst(nrst), .send(send), .msg_valid(msg_valid),
    .net_cmd(net_cmd), .net_ref(net_ref), .net_aux_a(na), .net_aux_b(nb),
    .net_aux_c(nc), .net_aux_d(nd)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic close_out();
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      close_out();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    par_wr = 1'b1;
    par_addr = a;
    par_wdata = d;
    tick(1);
    par_wr = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    par_rd = 1'b1;
    par_addr = a;
    tick(1);
    par_rd = 1'b0;
    chk($sformatf("register %h", a), par_rdata, exp);
    tick(1);
  endtask

  task automatic msg();
    send = 1'b1;
    tick(1);
    send = 1'b0;
  endtask

  // Counts edges from the taken message until loss shows, bounded
  task automatic wait_loss();
    n = 0;
    do begin
      tick(1);
      n = n + 1;
    end while (comm_loss !== 1'b1 && n < 60);
  endtask

  initial begin
    errors = 0;
    comparisons = 0;
    cyc = 0;
    nrst = 1'b0;
    par_wr = 1'b0;
    par_rd = 1'b0;
    par_addr = 6'h00;
    par_wdata = 32'h0;
    send = 1'b0;
    ref16 = 1'b0;
    tick(2);
    nrst = 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(ra[i], rv[i]);
    end
    chk("cmd enable", drv_cmd_en, 32'h1);
    chk("aux enables", drv_aux_en, 32'h0);
    wr(`CLFA_OFS_TIMEOUT, 32'hB5);
    rd(`CLFA_OFS_TIMEOUT, 32'hA);
    wr(`CLFA_OFS_TIMEOUT, 32'hB4);
    rd(`CLFA_OFS_TIMEOUT, 32'hB4);
    wr(`CLFA_OFS_ACTION, 32'h5);
    rd(`CLFA_OFS_ACTION, 32'h0);
    wr(`CLFA_OFS_IOEN, 32'h1F);
    rd(`CLFA_OFS_IOACT, 32'h1);
    chk("aux enables", drv_aux_en, 32'h0);
    wr(`CLFA_OFS_IOACT, 32'h0);
    wr(`CLFA_OFS_RESTART, 32'h1);
    tick(3);
    rd(`CLFA_OFS_RESTART, 32'h0);
    rd(`CLFA_OFS_IOACT, 32'h1F);
    chk("aux enables", drv_aux_en, 32'hF);
    msg();
    tick(2);
    chk("drive cmd", drv_cmd, net_cmd);
    chk("drive aux d", dd, nd);
    chk("drive ref", drv_ref, net_ref);
    chk("drive aux a", da, na);
    chk("drive aux b", db, nb);
    chk("drive aux c", dc, nc);
    for (int t = 1; t <= 2; t++) begin
      wr(`CLFA_OFS_TIMEOUT, t);
      msg();
      wait_loss();
      chk("loss delay", n, t * SEC + 2);
    end
    tick(12);
    chk("loss held", comm_loss, 32'h1);
    msg();
    tick(1);
    chk("loss cleared", comm_loss, 32'h0);
    wr(`CLFA_OFS_FB_CMD, 32'h1234);
    wr(`CLFA_OFS_FB_REF, 32'hABCD);
    wr(`CLFA_OFS_FB_AUX, 32'h5A5A);
    wr(`CLFA_OFS_ACTION, 32'h3);
    tick(2);
    wait_loss();
    tick(3);
    chk("hold cmd", drv_cmd, net_cmd);
    chk("hold fault", drv_fault, 32'h0);
    for (int a = 4; a >= 0; a--) begin
      if (a != 3) begin
        wr(`CLFA_OFS_ACTION, a);
        tick(2);
        chk("loss cmd", drv_cmd, (a == 4) ? 32'h1234 : 32'h0);
        chk("loss ref", drv_ref, (a == 4) ? 32'hABCD : 32'h0);
        chk("loss aux a", da, (a == 4) ? 32'h5A5A : 32'h0);
        chk("loss fault", drv_fault, (a == 0));
        chk("loss stop", drv_stop, (a <= 1));
      end
    end
    ref16 = 1'b1;
    wr(`CLFA_OFS_ACTION, 32'h4);
    wr(`CLFA_OFS_FB_REF, 32'h0001ABCD);
    tick(3);
    chk("upper word error", flt_cfg_err, 32'h1);
    chk("upper word fault", drv_fault, 32'h1);
    wr(`CLFA_OFS_FB_REF, 32'h0000ABCD);
    tick(2);
    chk("upper word error", flt_cfg_err, 32'h0);
    chk("upper word fault", drv_fault, 32'h0);
    wr(`CLFA_OFS_TIMEOUT, 32'h0);
    tick(2);
    chk("disabled loss", comm_loss, 32'h0);
    tick(30);
    chk("disabled loss", comm_loss, 32'h0);
    wr(`CLFA_OFS_IOEN, 32'h1E);
    wr(`CLFA_OFS_RESTART, 32'h1);
    tick(3);
    chk("cmd enable", drv_cmd_en, 32'h0);
    chk("drive cmd off", drv_cmd, 32'h0);
    chk("drive ref off", drv_ref, 32'h0);
    chk("drive aux c", dc, nc);
    wr(`CLFA_OFS_TIMEOUT, 32'h32);
    wr(`CLFA_OFS_RESTART, 32'h2);
    rd(`CLFA_OFS_RESTART, 32'h2);
    wr(`CLFA_OFS_RESTART, 32'h1);
    tick(3);
    rd(`CLFA_OFS_TIMEOUT, 32'hA);
    rd(`CLFA_OFS_IOEN, 32'h1);
    rd(`CLFA_OFS_IOACT, 32'h1);
    rd(`CLFA_OFS_RESTART, 32'h0);
    wr(`CLFA_OFS_IOEN, 32'h3);
    wr(`CLFA_OFS_RESTART, 32'h1);
    tick(3);
    rd(`CLFA_OFS_IOACT, 32'h3);
    nrst = 1'b0;
    tick(2);
    nrst = 1'b1;
    rd(`CLFA_OFS_IOACT, 32'h1);
    rd(`CLFA_OFS_RESTART, 32'h0);
    chk("loss after reset", comm_loss, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
